// ---- core/sef_front_end.sv ----
`timescale 1ns/1ps
//
// Contract
// - deselected: output pin released, device idle
// - ignore bus until chip select falls
// - sample input bits on rising clock
// - change output only on falling clock
// - all bytes shifted msb first
// - first eight bits form decoded instruction
// - first bit at first rising edge
// - stopped clock keeps state, resumes later
// - write refused unless latch already set
// - enable command sets, disable clears latch
// - latch cleared at reset, write done
// - read drives both levels, shifts data
// - protect pin plus lock bit gate status
// - standby when deselected and not writing
// - data transfers are whole bytes
// - code 06 sets the latch
// - code 04 clears the latch
// - write after enable needs deselection first
//
module sef_front_end
    import sef_pkg::*;
#(
    parameter int ADDR_BYTES = SEF_ADDR_BYTES
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_n_o,
    input wire logic protect_lock_bit_i,
    input wire logic wip_i,
    input wire logic write_done_i,
    input wire logic [SEF_BYTE_W-1:0] tx_byte_i,
    output logic write_enable_latch_o,
    output logic status_write_ok_o,
    output logic cmd_valid_o,
    output logic [SEF_BYTE_W-1:0] cmd_o,
    output logic rx_valid_o,
    output logic [SEF_BYTE_W-1:0] rx_byte_o,
    output logic rx_is_addr_o,
    output logic tx_next_o,
    output logic frame_end_o,
    output logic active_o,
    output logic standby_o
);

    localparam int CNT_W = $clog2(ADDR_BYTES + 1);
    localparam logic [CNT_W-1:0] ADDR_LAST = CNT_W'(ADDR_BYTES - 1);
    localparam logic [CNT_W-1:0] CNT_STEP = CNT_W'(1);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    // ============================================================
    // link side: frame framing and power-up arming
    // ============================================================
    logic frame_rst_n;
    logic armed;
    logic wel_l;
    logic sr_ok_l;
    logic write_enable_latch;
    logic sr_ok;

    // select high holds all frame state in reset, so a frame
    // cut short leaves nothing behind
    assign frame_rst_n = rstn_i & ~cs_n_i;

    // armed only by a real high-to-low select edge after power-up
    always_ff @(negedge cs_n_i or negedge rstn_i) begin
        if (!rstn_i) begin
            armed <= SEF_LATCH_RST;
        end else begin
            armed <= 1'b1;
        end
    end

    // latch and protect levels into the serial clock domain;
    // they pass the two stages on the opcode clocks of the next frame
    sef_sync #(
        .WIDTH(2),
        .RST_VAL(2'h0)
    ) u_link_sync (
        .clk_i(sck_i),
        .rstn_i(rstn_i),
        .d_i({write_enable_latch, sr_ok}),
        .q_o({wel_l, sr_ok_l})
    );

    // ============================================================
    // link side: receive shifter and instruction decode
    // ============================================================
    sef_phase_t phase;
    sef_phase_t next_phase;
    logic [2:0] bit_cnt;
    logic [2:0] next_bit_cnt;
    logic [SEF_BYTE_W-1:0] shreg;
    logic [SEF_BYTE_W-1:0] next_shreg;
    logic [CNT_W-1:0] byte_cnt;
    logic [CNT_W-1:0] next_byte_cnt;
    logic rd_mode;
    logic next_rd_mode;
    logic cmd_tgl;
    logic next_cmd_tgl;
    logic rx_tgl;
    logic next_rx_tgl;
    logic [SEF_BYTE_W-1:0] op_hold;
    logic [SEF_BYTE_W-1:0] next_op_hold;
    logic [SEF_BYTE_W-1:0] rx_hold;
    logic [SEF_BYTE_W-1:0] next_rx_hold;
    logic rx_addr_hold;
    logic next_rx_addr_hold;
    logic [SEF_BYTE_W-1:0] byte_in;
    logic byte_done;
    logic cmd_go;
    logic rx_go;

    assign byte_in = {shreg[SEF_BYTE_W-2:0], si_i};
    assign byte_done = (bit_cnt == SEF_BIT_LAST);

    // next values of the frame; nothing here counts time, so a
    // paused clock simply leaves everything where it was
    always_comb begin
        next_phase = phase;
        next_shreg = byte_in;
        next_bit_cnt = bit_cnt + SEF_BIT_STEP;
        next_byte_cnt = byte_cnt;
        next_rd_mode = rd_mode;
        cmd_go = 1'b0;
        rx_go = 1'b0;
        next_rx_addr_hold = rx_addr_hold;
        if (!armed) begin
            next_phase = SEF_PH_IGNORE;
        end else if (byte_done) begin
            unique case (phase)
                SEF_PH_OPCODE: begin
                    // decode the eight bits just completed
                    next_phase = SEF_PH_IGNORE;
                    unique case (byte_in)
                        SEF_OP_WRITE_ENABLE, SEF_OP_WRITE_DISABLE: begin
                            cmd_go = 1'b1;
                        end
                        SEF_OP_WRITE: begin
                            if (wel_l) begin
                                cmd_go = 1'b1;
                                next_phase = SEF_PH_ADDR;
                            end
                        end
                        SEF_OP_WRITE_STATUS: begin
                            if (wel_l && sr_ok_l) begin
                                cmd_go = 1'b1;
                                next_phase = SEF_PH_DATA;
                            end
                        end
                        SEF_OP_READ: begin
                            cmd_go = 1'b1;
                            next_phase = SEF_PH_ADDR;
                        end
                        SEF_OP_READ_STATUS: begin
                            cmd_go = 1'b1;
                            next_phase = SEF_PH_DATA;
                            next_rd_mode = 1'b1;
                        end
                        default: begin
                            next_phase = SEF_PH_IGNORE;
                        end
                    endcase
                end
                SEF_PH_ADDR: begin
                    rx_go = 1'b1;
                    next_rx_addr_hold = 1'b1;
                    next_byte_cnt = byte_cnt + CNT_STEP;
                    if (byte_cnt == ADDR_LAST) begin
                        next_phase = SEF_PH_DATA;
                        next_rd_mode = (op_hold == SEF_OP_READ);
                    end
                end
                SEF_PH_DATA: begin
                    // bytes coming in during a read are don't-care
                    rx_go = ~rd_mode;
                    next_rx_addr_hold = 1'b0;
                end
                SEF_PH_IGNORE: begin
                    next_phase = SEF_PH_IGNORE;
                end
            endcase
        end
        next_cmd_tgl = cmd_tgl ^ cmd_go;
        next_op_hold = cmd_go ? byte_in : op_hold;
        next_rx_tgl = rx_tgl ^ rx_go;
        next_rx_hold = rx_go ? byte_in : rx_hold;
    end

    // frame state, cleared whenever select is high
    always_ff @(posedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            phase <= SEF_PH_OPCODE;
            bit_cnt <= SEF_BIT_FIRST;
            shreg <= SEF_BYTE_RST;
            byte_cnt <= CNT_ZERO;
            rd_mode <= SEF_LATCH_RST;
        end else begin
            phase <= next_phase;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            byte_cnt <= next_byte_cnt;
            rd_mode <= next_rd_mode;
        end
    end

    // event toggles and held words survive deselection, so the
    // core side never sees a false event from a frame reset
    always_ff @(posedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_tgl <= SEF_LATCH_RST;
            rx_tgl <= SEF_LATCH_RST;
            op_hold <= SEF_BYTE_RST;
            rx_hold <= SEF_BYTE_RST;
            rx_addr_hold <= SEF_LATCH_RST;
        end else begin
            cmd_tgl <= next_cmd_tgl;
            rx_tgl <= next_rx_tgl;
            op_hold <= next_op_hold;
            rx_hold <= next_rx_hold;
            rx_addr_hold <= next_rx_addr_hold;
        end
    end

    // ============================================================
    // link side: transmit shifter on the falling clock edge
    // ============================================================
    logic [SEF_BYTE_W-1:0] tx_sh;
    logic [SEF_BYTE_W-1:0] next_tx_sh;
    logic tx_on;
    logic next_tx_on;
    logic tx_tgl;
    logic next_tx_tgl;
    logic tx_load;

    // a new byte is taken at the falling edge after the last bit of the byte before
    assign tx_load = rd_mode && (bit_cnt == SEF_BIT_FIRST);

    always_comb begin
        next_tx_sh = {tx_sh[SEF_BYTE_W-2:0], 1'b0};
        next_tx_on = tx_on;
        if (tx_load) begin
            next_tx_sh = tx_byte_i;
            next_tx_on = 1'b1;
        end
        next_tx_tgl = tx_tgl ^ tx_load;
    end

    always_ff @(negedge sck_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx_sh <= SEF_BYTE_RST;
            tx_on <= SEF_LATCH_RST;
        end else begin
            tx_sh <= next_tx_sh;
            tx_on <= next_tx_on;
        end
    end

    always_ff @(negedge sck_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_tgl <= SEF_LATCH_RST;
        end else begin
            tx_tgl <= next_tx_tgl;
        end
    end

    // push-pull while reading, released whenever deselected
    assign so_o = tx_sh[SEF_BYTE_W-1];
    assign so_oe_n_o = ~(tx_on & ~cs_n_i);

    // ============================================================
    // core side: pin and event synchronisers
    // ============================================================
    logic cs_s;
    logic wp_s;
    logic [2:0] tgl_s;
    logic [2:0] tgl_seen;
    logic [2:0] next_tgl_seen;
    logic cs_prev;
    logic next_cs_prev;

    sef_sync #(
        .WIDTH(5),
        .RST_VAL({SEF_CS_IDLE, SEF_WP_IDLE, 3'h0})
    ) u_core_sync (
        .clk_i(core_clk_i),
        .rstn_i(rstn_i),
        .d_i({cs_n_i, wp_n_i, cmd_tgl, rx_tgl, tx_tgl}),
        .q_o({cs_s, wp_s, tgl_s})
    );

    // ============================================================
    // core side: write enable latch, protection, event outputs
    // ============================================================
    logic cmd_ev;
    logic rx_ev;
    logic tx_ev;
    logic next_wel;
    logic next_sr_ok;
    logic next_cmd_valid;
    logic [SEF_BYTE_W-1:0] next_cmd;
    logic next_rx_valid;
    logic [SEF_BYTE_W-1:0] next_rx_byte;
    logic next_rx_is_addr;
    logic next_tx_next;
    logic next_frame_end;
    logic next_active;
    logic next_standby;

    assign cmd_ev = tgl_s[2] ^ tgl_seen[2];
    assign rx_ev = tgl_s[1] ^ tgl_seen[1];
    assign tx_ev = tgl_s[0] ^ tgl_seen[0];

    // held link words are stable for a whole byte after a toggle
    always_comb begin
        next_tgl_seen = tgl_s;
        next_cs_prev = cs_s;
        next_wel = write_enable_latch;
        if (write_done_i) begin
            next_wel = 1'b0;
        end
        if (cmd_ev && op_hold == SEF_OP_WRITE_DISABLE) begin
            next_wel = 1'b0;
        end
        if (cmd_ev && op_hold == SEF_OP_WRITE_ENABLE) begin
            next_wel = 1'b1;
        end
        next_sr_ok = ~protect_lock_bit_i | wp_s;
        next_cmd_valid = cmd_ev;
        next_cmd = cmd_ev ? op_hold : cmd_o;
        next_rx_valid = rx_ev;
        next_rx_byte = rx_ev ? rx_hold : rx_byte_o;
        next_rx_is_addr = rx_ev ? rx_addr_hold : rx_is_addr_o;
        next_tx_next = tx_ev;
        next_frame_end = cs_s & ~cs_prev;
        next_active = ~cs_s;
        next_standby = cs_s & ~wip_i;
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tgl_seen <= 3'h0;
            cs_prev <= SEF_CS_IDLE;
            write_enable_latch <= SEF_LATCH_RST;
            sr_ok <= SEF_LATCH_RST;
            cmd_valid_o <= 1'b0;
            cmd_o <= SEF_BYTE_RST;
            rx_valid_o <= 1'b0;
            rx_byte_o <= SEF_BYTE_RST;
            rx_is_addr_o <= 1'b0;
            tx_next_o <= 1'b0;
            frame_end_o <= 1'b0;
            active_o <= 1'b0;
            standby_o <= 1'b0;
        end else begin
            tgl_seen <= next_tgl_seen;
            cs_prev <= next_cs_prev;
            write_enable_latch <= next_wel;
            sr_ok <= next_sr_ok;
            cmd_valid_o <= next_cmd_valid;
            cmd_o <= next_cmd;
            rx_valid_o <= next_rx_valid;
            rx_byte_o <= next_rx_byte;
            rx_is_addr_o <= next_rx_is_addr;
            tx_next_o <= next_tx_next;
            frame_end_o <= next_frame_end;
            active_o <= next_active;
            standby_o <= next_standby;
        end
    end

    assign write_enable_latch_o = write_enable_latch;
    assign status_write_ok_o = sr_ok;

endmodule

// ---- core/sef_pkg.sv ----
// ============================================================
// shared constants for the serial memory front end
// ============================================================
package sef_pkg;

    // byte framing on the serial link
    localparam int SEF_BYTE_W = 8;
    localparam int SEF_ADDR_BYTES = 2;
    localparam logic [2:0] SEF_BIT_FIRST = 3'h0;
    localparam logic [2:0] SEF_BIT_LAST = 3'h7;
    localparam logic [2:0] SEF_BIT_STEP = 3'h1;

    // instruction codes, msb first on the wire
    localparam logic [7:0] SEF_OP_WRITE_STATUS = 8'h01;
    localparam logic [7:0] SEF_OP_WRITE = 8'h02;
    localparam logic [7:0] SEF_OP_READ = 8'h03;
    localparam logic [7:0] SEF_OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] SEF_OP_READ_STATUS = 8'h05;
    localparam logic [7:0] SEF_OP_WRITE_ENABLE = 8'h06;

    // reset values
    localparam logic SEF_LATCH_RST = 1'b0;
    localparam logic SEF_CS_IDLE = 1'b1;
    localparam logic SEF_WP_IDLE = 1'b1;
    localparam logic [7:0] SEF_BYTE_RST = 8'h00;

    // where the link is inside one selected frame
    typedef enum logic [1:0] {
        SEF_PH_OPCODE,
        SEF_PH_ADDR,
        SEF_PH_DATA,
        SEF_PH_IGNORE
    } sef_phase_t;

endpackage

// ---- core/sef_sync.sv ----
`timescale 1ns/1ps
// ============================================================
// two flip-flop level synchroniser, two stages per bit
// ============================================================
module sef_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    // first stage feeds only the second stage
    always_comb begin
        next_meta = d_i;
        next_q = meta;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            meta <= next_meta;
            q_o <= next_q;
        end
    end

endmodule

// ---- verification/sef_fe_monitor.sv ----
`timescale 1ns/1ps
// ========
// port checks for the serial front end
module sef_fe_monitor
    import sef_pkg::*;
#(
    parameter int ADDR_BYTES = SEF_ADDR_BYTES
) (
    input wire logic core_clk_i,
    input wire logic rstn_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic wp_n_i,
    input wire logic so_o,
    input wire logic so_oe_n_o,
    input wire logic protect_lock_bit_i,
    input wire logic wip_i,
    input wire logic write_done_i,
    input wire logic write_enable_latch_o,
    input wire logic status_write_ok_o,
    input wire logic cmd_valid_o,
    input wire logic [SEF_BYTE_W-1:0] cmd_o,
    input wire logic frame_end_o,
    input wire logic active_o,
    input wire logic standby_o
);
    // one core domain; reset also masks the sync stages
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rstn_i);

    release_idle_a: assert property (cs_n_i |-> so_oe_n_o)
        else $error("so driven while deselected");
    // only valid for slow reads, where sck stays low a whole core cycle
    fall_update_a: assert property (!so_oe_n_o && $changed(so_o) |-> !sck_i)
        else $error("so moved with sck high");
    enable_set_a: assert property (cmd_valid_o && cmd_o == SEF_OP_WRITE_ENABLE |-> write_enable_latch_o)
        else $error("enable did not set latch");
    disable_clear_a: assert property (cmd_valid_o && cmd_o == SEF_OP_WRITE_DISABLE |-> !write_enable_latch_o)
        else $error("disable did not clear latch");
    write_gate_a: assert property (cmd_valid_o && cmd_o == SEF_OP_WRITE |-> $past(write_enable_latch_o))
        else $error("write taken without latch");
    done_clear_a: assert property (write_done_i |=> !write_enable_latch_o || cmd_valid_o)
        else $error("latch kept after write done");
    lock_hold_a: assert property ((protect_lock_bit_i && !wp_n_i) [*5] |-> !status_write_ok_o)
        else $error("status write open while locked");
    unlock_ok_a: assert property ((!protect_lock_bit_i) [*2] |-> status_write_ok_o)
        else $error("status write closed while unlocked");
    standby_on_a: assert property ((cs_n_i && !wip_i) [*5] |-> standby_o)
        else $error("no standby when idle");
    active_only_a: assert property (active_o |-> !standby_o && !$past(cs_n_i, 3))
        else $error("active and standby together");
    frame_close_a: assert property ($rose(cs_n_i) |-> ##[2:5] frame_end_o)
        else $error("no frame end after deselect");
    cmd_known_a: assert property (cmd_valid_o |-> cmd_o inside {[8'h01:8'h06]})
        else $error("unknown code accepted");
endmodule

bind sef_front_end sef_fe_monitor #(.ADDR_BYTES(ADDR_BYTES)) u_mon (.*);

// ---- verification/sef_host_model.sv ----
`timescale 1ns/1ps
// ========
// host side of the link, mode 0, msb first
module sef_host_model (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    input wire logic so_i,
    input wire logic so_oe_n_i
);
    realtime half_ns = 50.0;
    int stall_bit = -1;
    logic oe_seen;

    // sck stands still low outside frames
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        oe_seen = 1'b1;
    end

    // a fresh select fall arms the device; held low for the whole operation
    task automatic select();
        cs_n_o = 1'b0;
        #(half_ns);
    endtask

    // every write begins in a new frame
    task automatic deselect();
        #(half_ns);
        cs_n_o = 1'b1;
        si_o = ~si_o; // released line shows no stale bit
    endtask

    // data set while sck low, read back at the rise
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            si_o = tx[i];
            #(half_ns);
            sck_o = 1'b1;
            rx[i] = so_oe_n_i ? ~so_i : so_i; // released line reads no stale bit
            oe_seen = so_oe_n_i;
            #(half_ns);
            sck_o = 1'b0;
            if (i == stall_bit) #(40 * half_ns);
        end
    endtask
endmodule

// ---- verification/tb_sef_front_end.sv ----
`timescale 1ns/1ps
// ========
// self-checking bench for the serial front end
module tb_sef_front_end;
    import sef_pkg::*;
    logic core_clk_i, rstn_i, sck_i, cs_n_i, si_i, wp_n_i, so_o, so_oe_n_o;
    logic protect_lock_bit_i, wip_i, write_done_i, write_enable_latch_o, status_write_ok_o;
    logic cmd_valid_o, rx_valid_o, rx_is_addr_o, tx_next_o, frame_end_o, active_o, standby_o;
    logic [7:0] tx_byte_i, cmd_o, rx_byte_o, rd;
    logic [31:0] rx_log = 32'h0;
    logic [3:0] addr_log = 4'h0;
    int num_errors = 0;
    int n_compared = 0;
    int n_cmd = 0;
    int n_rx = 0;

    sef_front_end DUT (.*);
    sef_host_model host (.sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o), .so_oe_n_i(so_oe_n_o));

    // ========
    // clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    // log core events mid-cycle, away from the edge that launches them;
    // next read byte follows each load
    always @(negedge core_clk_i) begin
        if (cmd_valid_o === 1'b1) n_cmd++;
        if (rx_valid_o === 1'b1) begin
            n_rx++;
            rx_log <= {rx_log[23:0], rx_byte_o};
            addr_log <= {addr_log[2:0], rx_is_addr_o};
        end
        if (tx_next_o === 1'b1) tx_byte_i <= #1 ~tx_byte_i;
    end

    // ========
    // tasks
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic results();
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // one frame of nb bytes, the last cut to nbits; waits for the frame end
    task automatic op(input logic [39:0] w, input int nb, input int nbits);
        int k;
        host.select();
        for (k = 0; k < nb; k++)
            host.xfer(w[8*(nb-1-k) +: 8], (k == nb - 1) ? nbits : 8, rd);
        host.deselect();
        k = 0;
        while (frame_end_o !== 1'b1 && k < 100) begin
            cyc(1);
            k++;
        end
        if (frame_end_o !== 1'b1) begin
            num_errors++;
            $display("ERROR frame_end_o expected 1 seen %b", frame_end_o);
        end
        cyc(4);
    endtask

    // ========
    // sequence
    initial begin
        rstn_i = 1'b0;
        wp_n_i = 1'b1;
        protect_lock_bit_i = 1'b0;
        wip_i = 1'b0;
        write_done_i = 1'b0;
        tx_byte_i = 8'hC3;
        cyc(8);
        host.cs_n_o = 1'b0; // select already low at release
        cyc(8);
        rstn_i = 1'b1;
        cyc(4);
        host.xfer(SEF_OP_WRITE_ENABLE, 8, rd);
        host.deselect();
        cyc(10);
        chk("latch unarmed", 0, write_enable_latch_o);
        chk("cmd unarmed", 0, n_cmd);
        host.half_ns = 3.0; // 6 ns link clock
        op({32'h0, SEF_OP_WRITE_ENABLE}, 1, 8);
        host.half_ns = 50.0;
        chk("latch set", 1, write_enable_latch_o);
        chk("cmd_o", SEF_OP_WRITE_ENABLE, cmd_o);
        op({32'h0, SEF_OP_WRITE_DISABLE}, 1, 8);
        chk("latch clear", 0, write_enable_latch_o);
        op({32'h0, SEF_OP_WRITE_ENABLE}, 1, 5);
        chk("short latch", 0, write_enable_latch_o);
        chk("short cmd", 2, n_cmd);
        op({8'h0, SEF_OP_WRITE, 24'h1234A5}, 4, 8);
        chk("locked write", 2, n_cmd + n_rx);
        op({16'h0, SEF_OP_WRITE_ENABLE, SEF_OP_WRITE, 8'h12}, 3, 8);
        chk("joined write", 3, n_cmd + n_rx);
        chk("joined latch", 1, write_enable_latch_o);
        host.stall_bit = 3;
        op({8'h0, SEF_OP_WRITE, 24'h1234A5}, 4, 8);
        host.stall_bit = -1;
        chk("write cmd", SEF_OP_WRITE, cmd_o);
        chk("rx bytes", 24'h1234A5, rx_log[23:0]);
        chk("rx kinds", 3'b110, addr_log[2:0]);
        write_done_i = 1'b1;
        cyc(1);
        write_done_i = 1'b0;
        cyc(2);
        chk("latch done", 0, write_enable_latch_o);
        for (int i = 0; i < 4; i++) begin
            protect_lock_bit_i = i[1];
            wp_n_i = i[0];
            cyc(6);
            chk("status ok", !(i == 2), status_write_ok_o);
        end
        wp_n_i = 1'b0;
        op({32'h0, SEF_OP_WRITE_ENABLE}, 1, 8);
        op({24'h0, SEF_OP_WRITE_STATUS, 8'h8C}, 2, 8);
        chk("status refused", 5, n_cmd);
        op({32'h0, 8'h00}, 1, 8);
        chk("unknown code", 5, n_cmd);
        wp_n_i = 1'b1;
        cyc(6);
        op({24'h0, SEF_OP_WRITE_STATUS, 8'h8C}, 2, 8);
        chk("status taken", SEF_OP_WRITE_STATUS, cmd_o);
        op({24'h0, SEF_OP_READ_STATUS, 8'hFF}, 2, 8);
        chk("status byte", 8'hC3, rd);
        chk("so driven", 0, host.oe_seen);
        chk("so released", 1, so_oe_n_o);
        tx_byte_i = 8'h5A;
        op({SEF_OP_READ, 16'h0010, 16'hFFFF}, 5, 8);
        chk("second byte", 8'hA5, rd);
        wip_i = 1'b1;
        cyc(6);
        chk("standby busy", 0, standby_o);
        wip_i = 1'b0;
        host.select();
        cyc(6);
        chk("active", 1, active_o);
        host.deselect();
        cyc(8);
        chk("standby idle", 1, standby_o);
        results();
    end
endmodule
